// file: logic/glcr_port.v
// Three-port I/O line control slice with AXI4-Lite register access
`timescale 1ns/100ps
`include "glcr_defines.vh"

module glcr_port #(
    parameter LINES = 32
) (
    input wire CLK,
    input wire SRST,
    input wire CE,
    input wire [31:0] AWADDR,
    input wire AWVALID,
    output reg AWREADY,
    input wire [31:0] WDATA,
    input wire [3:0] WSTRB,
    input wire WVALID,
    output reg WREADY,
    output reg [1:0] BRESP,
    output reg BVALID,
    input wire BREADY,
    input wire [31:0] ARADDR,
    input wire ARVALID,
    output reg ARREADY,
    output reg [31:0] RDATA,
    output reg [1:0] RRESP,
    output reg RVALID,
    input wire RREADY,
    input wire [3*LINES-1:0] LINE_IN,
    output reg [3*LINES-1:0] LINE_OUT,
    output reg [3*LINES-1:0] LINE_OE_N,
    output reg IRQ
);

// =====================================================================
// Helpers
function [2:0] port_sel;
    input [31:0] a;
    begin
        if ((a & `GLCR_PORT_MASK) == `GLCR_BASE_FIRST) begin
            port_sel = 3'h4;
        end else if ((a & `GLCR_PORT_MASK) == `GLCR_BASE_SECOND) begin
            port_sel = 3'h5;
        end else if ((a & `GLCR_PORT_MASK) == `GLCR_BASE_THIRD) begin
            port_sel = 3'h6;
        end else begin
            port_sel = 3'h0;
        end
    end
endfunction

function [31:0] pick;
    input [3*LINES-1:0] v;
    input [1:0] p;
    reg [3*LINES-1:0] t;
    begin
        t = v >> {p, 5'h0};
        pick = t[31:0];
    end
endfunction

function [3*LINES-1:0] place;
    input [31:0] w;
    input [1:0] p;
    begin
        place = {{(2*LINES){1'b0}}, w} << {p, 5'h0};
    end
endfunction

// =====================================================================
// State
reg [3*LINES-1:0] filt_en;
reg [3*LINES-1:0] irq_en;
reg [3*LINES-1:0] wr_permit;
reg [3*LINES-1:0] chg_stat;
reg [3*LINES-1:0] sync1;
reg [3*LINES-1:0] sync2;
reg [3*LINES-1:0] line_lvl;
reg [3*LINES-1:0] filt_lvl;
reg aw_full;
reg w_full;
reg [31:0] aw_addr;
reg [31:0] w_data;
reg [3:0] w_strb;

reg [3*LINES-1:0] next_drive;
reg [3*LINES-1:0] next_oe_n;
reg [3*LINES-1:0] next_filt_en;
reg [3*LINES-1:0] next_irq_en;
reg [3*LINES-1:0] next_wr_permit;
reg [3*LINES-1:0] next_chg_stat;
reg [3*LINES-1:0] next_filt_lvl;
reg [3*LINES-1:0] bits_m;
reg [3*LINES-1:0] lane_m;
reg [3*LINES-1:0] data_m;
reg [3*LINES-1:0] upd;
reg [31:0] strb_bits;
reg [2:0] wsel;
reg wr_ok;
reg [2:0] rsel;
reg [31:0] rd_word;
reg rd_ok;

wire wr_go = aw_full && w_full && !BVALID;

// =====================================================================
// Register writes, filter and change detection
always @* begin
    strb_bits = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
    wsel = port_sel(aw_addr);
    lane_m = place(strb_bits, wsel[1:0]);
    data_m = place(w_data, wsel[1:0]);
    bits_m = data_m & lane_m;
    next_drive = LINE_OUT;
    next_oe_n = LINE_OE_N;
    next_filt_en = filt_en;
    next_irq_en = irq_en;
    next_wr_permit = wr_permit;
    next_chg_stat = chg_stat;
    wr_ok = 1'b1;
    if (wr_go && wsel[2]) begin
        case (aw_addr[8:0])
            `GLCR_OUTPUT_ENABLE_SET: next_oe_n = LINE_OE_N & ~bits_m;
            `GLCR_OUTPUT_DISABLE: next_oe_n = LINE_OE_N | bits_m;
            `GLCR_FILTER_ENABLE: next_filt_en = filt_en | bits_m;
            `GLCR_FILTER_DISABLE: next_filt_en = filt_en & ~bits_m;
            `GLCR_DRIVE_LEVEL_SET: next_drive = LINE_OUT | bits_m;
            `GLCR_DRIVE_LEVEL_CLEAR: next_drive = LINE_OUT & ~bits_m;
            `GLCR_DRIVE_LEVEL_STATUS: begin
                // Only permitted lines take the written level
                next_drive = (LINE_OUT & ~(lane_m & wr_permit)) | (data_m & lane_m & wr_permit);
            end
            `GLCR_CHANGE_IRQ_ENABLE: next_irq_en = irq_en | bits_m;
            `GLCR_CHANGE_IRQ_DISABLE: next_irq_en = irq_en & ~bits_m;
            `GLCR_CHANGE_STATUS: next_chg_stat = chg_stat & ~bits_m;
            `GLCR_DIRECT_WRITE_ENABLE: next_wr_permit = wr_permit | bits_m;
            `GLCR_DIRECT_WRITE_DISABLE: next_wr_permit = wr_permit & ~bits_m;
            `GLCR_OUTPUT_STATUS, `GLCR_FILTER_STATUS, `GLCR_LINE_LEVEL_STATUS,
            `GLCR_CHANGE_IRQ_MASK, `GLCR_DIRECT_WRITE_PERMIT_STATUS: wr_ok = 1'b1;
            default: wr_ok = 1'b0;
        endcase
    end else if (wr_go) begin
        wr_ok = 1'b0;
    end
    // Filtered level moves only after two equal samples when filter is on
    upd = ~filt_en | ~(line_lvl ^ sync2);
    next_filt_lvl = (upd & line_lvl) | (~upd & filt_lvl);
    // A new change wins over a clear in the same cycle
    next_chg_stat = next_chg_stat | ((next_filt_lvl ^ filt_lvl) & irq_en);
end

// =====================================================================
// Register reads
always @* begin
    rsel = port_sel(ARADDR);
    rd_word = 32'h0;
    rd_ok = rsel[2];
    case (ARADDR[8:0])
        `GLCR_OUTPUT_STATUS: rd_word = ~pick(LINE_OE_N, rsel[1:0]);
        `GLCR_FILTER_STATUS: rd_word = pick(filt_en, rsel[1:0]);
        `GLCR_DRIVE_LEVEL_STATUS: rd_word = pick(LINE_OUT, rsel[1:0]);
        `GLCR_LINE_LEVEL_STATUS: rd_word = pick(line_lvl, rsel[1:0]);
        `GLCR_CHANGE_IRQ_MASK: rd_word = pick(irq_en, rsel[1:0]);
        `GLCR_CHANGE_STATUS: rd_word = pick(chg_stat, rsel[1:0]);
        `GLCR_DIRECT_WRITE_PERMIT_STATUS: rd_word = pick(wr_permit, rsel[1:0]);
        `GLCR_OUTPUT_ENABLE_SET, `GLCR_OUTPUT_DISABLE, `GLCR_FILTER_ENABLE,
        `GLCR_FILTER_DISABLE, `GLCR_DRIVE_LEVEL_SET, `GLCR_DRIVE_LEVEL_CLEAR,
        `GLCR_CHANGE_IRQ_ENABLE, `GLCR_CHANGE_IRQ_DISABLE,
        `GLCR_DIRECT_WRITE_ENABLE, `GLCR_DIRECT_WRITE_DISABLE: rd_word = 32'h0;
        default: rd_ok = 1'b0;
    endcase
    if (!rd_ok) begin
        rd_word = 32'h0;
    end
end

// =====================================================================
// Line state and pin sampling
always @(posedge CLK) begin
    if (SRST) begin
        LINE_OUT <= `GLCR_RESET_WORD;
        LINE_OE_N <= `GLCR_RESET_DRIVER_OFF_N;
        filt_en <= `GLCR_RESET_WORD;
        irq_en <= `GLCR_RESET_WORD;
        wr_permit <= `GLCR_RESET_WORD;
        chg_stat <= `GLCR_RESET_WORD;
        sync1 <= `GLCR_RESET_WORD;
        sync2 <= `GLCR_RESET_WORD;
        line_lvl <= `GLCR_RESET_WORD;
        filt_lvl <= `GLCR_RESET_WORD;
        IRQ <= 1'b0;
    end else if (CE) begin
        // Driven level is stored independently of the driver enable
        LINE_OUT <= next_drive;
        LINE_OE_N <= next_oe_n;
        filt_en <= next_filt_en;
        irq_en <= next_irq_en;
        wr_permit <= next_wr_permit;
        chg_stat <= next_chg_stat;
        // Sampling stops with the clock enable and holds the last levels
        sync1 <= LINE_IN;
        sync2 <= sync1;
        line_lvl <= sync2;
        filt_lvl <= next_filt_lvl;
        IRQ <= |(next_chg_stat & next_irq_en);
    end
end

// =====================================================================
// AXI4-Lite write channel
always @(posedge CLK) begin
    if (SRST) begin
        AWREADY <= 1'b1;
        WREADY <= 1'b1;
        BVALID <= 1'b0;
        BRESP <= `GLCR_RESP_OKAY;
        aw_full <= 1'b0;
        w_full <= 1'b0;
        aw_addr <= 32'h0;
        w_data <= 32'h0;
        w_strb <= 4'h0;
    end else if (CE) begin
        if (AWVALID && AWREADY) begin
            AWREADY <= 1'b0;
            aw_full <= 1'b1;
            aw_addr <= AWADDR;
        end
        if (WVALID && WREADY) begin
            WREADY <= 1'b0;
            w_full <= 1'b1;
            w_data <= WDATA;
            w_strb <= WSTRB;
        end
        if (wr_go) begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            BVALID <= 1'b1;
            BRESP <= wr_ok ? `GLCR_RESP_OKAY : `GLCR_RESP_SLVERR;
        end
        if (BVALID && BREADY) begin
            BVALID <= 1'b0;
            AWREADY <= 1'b1;
            WREADY <= 1'b1;
        end
    end
end

// =====================================================================
// AXI4-Lite read channel
always @(posedge CLK) begin
    if (SRST) begin
        ARREADY <= 1'b1;
        RVALID <= 1'b0;
        RDATA <= 32'h0;
        RRESP <= `GLCR_RESP_OKAY;
    end else if (CE) begin
        if (ARVALID && ARREADY) begin
            ARREADY <= 1'b0;
            RVALID <= 1'b1;
            RDATA <= rd_word;
            RRESP <= rd_ok ? `GLCR_RESP_OKAY : `GLCR_RESP_SLVERR;
        end
        if (RVALID && RREADY) begin
            RVALID <= 1'b0;
            ARREADY <= 1'b1;
        end
    end
end

endmodule // glcr_port

// file: shared/glcr_defines.vh
// Register map and reset values of the three-port I/O line control slice
// =====================================================================
// Overview of operation
// - Writing one to output_disable turns that line's driver off; zeros ignored.
// - output_status bit reads one when driver enabled, zero for pure input.
// - Writing one to filter_enable switches that line's glitch filter on.
// - Writing one to filter_disable switches that line's glitch filter off.
// - filter_status bit reads one while that line's filter is active.
// - Writing one to drive_level_set makes that line's driven level high.
// - Writing one to drive_level_clear makes that line's driven level low.
// - drive_level_status returns the level scheduled for each line.
// - drive_level_status always readable; writable only on permitted lines.
// - line_level_status reports sampled pin level regardless of driver state.
// - Writing one to change_irq_enable enables change interrupt on that line.
// - Three independent ports decode the same layout at their own bases.
// - Writing one to change_irq_disable stops change interrupt on that line.
// - direct_write_permit_status bit decides whether a drive_level_status bit is written.
// - Line levels track only while clock runs; otherwise hold last sample.
// - Writing one to output_enable_set turns that line's driver on.
`ifndef GLCR_DEFINES_VH
`define GLCR_DEFINES_VH

// =====================================================================
// Port base addresses
`define GLCR_BASE_FIRST 32'hfffff400
`define GLCR_BASE_SECOND 32'hfffff600
`define GLCR_BASE_THIRD 32'hfffff800
`define GLCR_PORT_MASK 32'hfffffe00

// =====================================================================
// Register offsets within a port
`define GLCR_OUTPUT_ENABLE_SET 9'h010
`define GLCR_OUTPUT_DISABLE 9'h014
`define GLCR_OUTPUT_STATUS 9'h018
`define GLCR_FILTER_ENABLE 9'h020
`define GLCR_FILTER_DISABLE 9'h024
`define GLCR_FILTER_STATUS 9'h028
`define GLCR_DRIVE_LEVEL_SET 9'h030
`define GLCR_DRIVE_LEVEL_CLEAR 9'h034
`define GLCR_DRIVE_LEVEL_STATUS 9'h038
`define GLCR_LINE_LEVEL_STATUS 9'h03c
`define GLCR_CHANGE_IRQ_ENABLE 9'h040
`define GLCR_CHANGE_IRQ_DISABLE 9'h044
`define GLCR_CHANGE_IRQ_MASK 9'h048
`define GLCR_CHANGE_STATUS 9'h04c
`define GLCR_DIRECT_WRITE_ENABLE 9'h0a0
`define GLCR_DIRECT_WRITE_DISABLE 9'h0a4
`define GLCR_DIRECT_WRITE_PERMIT_STATUS 9'h0a8

// =====================================================================
// Reset values and bus answers
`define GLCR_RESET_WORD 96'h0
`define GLCR_RESET_DRIVER_OFF_N 96'hffffffffffffffffffffffff
`define GLCR_RESP_OKAY 2'h0
`define GLCR_RESP_SLVERR 2'h2

`endif

// file: testbench/glcr_port_asserts.sv
// Bus and pin-effect assertions for the line control slice
`timescale 1ns/100ps
module glcr_port_asserts #(
    parameter LINES = 32
) (
    input wire CLK,
    input wire SRST,
    input wire AWVALID,
    input wire AWREADY,
    input wire WVALID,
    input wire WREADY,
    input wire [1:0] BRESP,
    input wire BVALID,
    input wire BREADY,
    input wire ARVALID,
    input wire ARREADY,
    input wire [31:0] RDATA,
    input wire [1:0] RRESP,
    input wire RVALID,
    input wire RREADY,
    input wire [3*LINES-1:0] LINE_OUT,
    input wire [3*LINES-1:0] LINE_OE_N
);
    // ====
    // Properties
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SRST);
    a_write_answer: assert property (AWVALID && AWREADY && WVALID && WREADY |-> ##2 BVALID)
        else $error("write answer missing");
    a_bresp_holds: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
        else $error("write answer dropped");
    a_read_answer: assert property (ARVALID && ARREADY |=> RVALID)
        else $error("read answer missing");
    a_rdata_holds: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
        else $error("read data dropped");
    a_write_busy: assert property (BVALID |-> !AWREADY && !WREADY)
        else $error("write taken while busy");
    a_read_busy: assert property (RVALID |-> !ARREADY)
        else $error("read taken while busy");
    a_driver_on_write: assert property ($changed(LINE_OE_N) |-> $rose(BVALID))
        else $error("driver changed without write");
    a_level_on_write: assert property ($changed(LINE_OUT) |-> $rose(BVALID))
        else $error("level changed without write");
    a_refused_zero: assert property (RVALID && RRESP == 2'h2 |-> RDATA == 32'h0)
        else $error("refused read data not zero");
endmodule // glcr_port_asserts

bind glcr_port glcr_port_asserts #(.LINES(LINES)) u_glcr_port_asserts (.CLK(CLK), .SRST(SRST),
    .AWVALID(AWVALID), .AWREADY(AWREADY), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
    .BVALID(BVALID), .BREADY(BREADY), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA),
    .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY), .LINE_OUT(LINE_OUT), .LINE_OE_N(LINE_OE_N));

// file: testbench/glcr_pins.sv
// Pin model: each line shows the slice's level when driven, else the far side's
`timescale 1ns/100ps
module glcr_pins #(
    parameter LINES = 32
) (
    input wire [3*LINES-1:0] line_out,
    input wire [3*LINES-1:0] line_oe_n,
    input wire [3*LINES-1:0] ext_level,
    output wire [3*LINES-1:0] line_in
);
    assign line_in = (line_oe_n & ext_level) | (~line_oe_n & line_out);
endmodule // glcr_pins

// file: testbench/glcr_port_tb.sv
// Register-level testbench of the three-port line control slice
`timescale 1ns/100ps
`include "glcr_defines.vh"
module glcr_port_tb;
    logic clk = 0, srst = 1, ce = 1;
    logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata, base, pins;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0] bresp, rresp;
    logic [95:0] line_in, line_out, line_oe_n, ext = 0;
    int errors = 0, n_compared = 0, cyc = 0;

    initial forever #4 clk = ~clk;

    glcr_port u_glcr_port (.CLK(clk), .SRST(srst), .CE(ce), .AWADDR(awaddr), .AWVALID(awvalid),
        .AWREADY(awready), .WDATA(wdata), .WSTRB(4'hf), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
        .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
        .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready), .LINE_IN(line_in),
        .LINE_OUT(line_out), .LINE_OE_N(line_oe_n), .IRQ(irq));
    glcr_pins u_glcr_pins (.line_out(line_out), .line_oe_n(line_oe_n), .ext_level(ext), .line_in(line_in));

    // ====
    // Checks and bus tasks
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        n_compared++;
        if (s !== e) begin
            errors++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic wr(input logic [8:0] o, input logic [31:0] d, input logic [1:0] r);
        @(posedge clk);
        awaddr <= base + o;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
            if (bvalid) begin
                bready <= 0;
                chk("bresp", r, bresp);
            end
        end while (!bvalid);
    endtask

    task automatic rd(input logic [8:0] o, input logic [31:0] e, input logic [1:0] r);
        @(posedge clk);
        araddr <= base + o;
        arvalid <= 1;
        rready <= 1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 0;
            if (rvalid) begin
                rready <= 0;
                chk("rresp", r, rresp);
                chk("rdata", e, rdata);
            end
        end while (!rvalid);
    endtask

    task automatic print_verdict;
        if (errors == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            print_verdict;
        end
    end

    // ====
    // Sequence, once per port
    initial begin
        repeat (5) @(posedge clk);
        srst <= 0;
        for (int p = 0; p < 3; p++) begin
            base = 32'hfffff400 + p * 32'h200;
            pins = 32'h5a5a1234 ^ p;
            ext[p*32 +: 32] <= pins;
            rd(`GLCR_OUTPUT_STATUS, 32'h0, 2'h0);
            wr(`GLCR_DRIVE_LEVEL_SET, 32'h000000f0, 2'h0);
            wr(`GLCR_DRIVE_LEVEL_CLEAR, 32'h00000030, 2'h0);
            rd(`GLCR_DRIVE_LEVEL_STATUS, 32'h000000c0, 2'h0);
            wr(`GLCR_OUTPUT_ENABLE_SET, 32'h000000cf, 2'h0);
            wr(`GLCR_OUTPUT_DISABLE, 32'h00000080, 2'h0);
            rd(`GLCR_OUTPUT_STATUS, 32'h0000004f, 2'h0);
            chk("line_oe_n", ~32'h4f, line_oe_n[p*32 +: 32]);
            repeat (4) @(posedge clk);
            rd(`GLCR_LINE_LEVEL_STATUS, (pins & ~32'h4f) | 32'h40, 2'h0);
            wr(`GLCR_OUTPUT_ENABLE_SET, 32'h00000080, 2'h0);
            chk("line_out", 32'h000000c0, line_out[p*32 +: 32]);
            wr(`GLCR_FILTER_ENABLE, 32'h000000a5, 2'h0);
            wr(`GLCR_FILTER_DISABLE, 32'h00000005, 2'h0);
            rd(`GLCR_FILTER_STATUS, 32'h000000a0, 2'h0);
            rd(`GLCR_OUTPUT_DISABLE, 32'h0, 2'h0);
            wr(`GLCR_DRIVE_LEVEL_STATUS, 32'hffffffff, 2'h0);
            wr(`GLCR_DIRECT_WRITE_ENABLE, 32'h00000080, 2'h0);
            wr(`GLCR_DRIVE_LEVEL_STATUS, 32'h0, 2'h0);
            rd(`GLCR_DRIVE_LEVEL_STATUS, 32'h00000040, 2'h0);
            wr(`GLCR_CHANGE_IRQ_ENABLE, 32'h00000100, 2'h0);
            rd(`GLCR_CHANGE_IRQ_MASK, 32'h00000100, 2'h0);
            ext[p*32+8] <= ~pins[8];
            repeat (8) @(posedge clk);
            chk("irq", 32'h1, {31'h0, irq});
            rd(`GLCR_CHANGE_STATUS, 32'h00000100, 2'h0);
            wr(`GLCR_CHANGE_STATUS, 32'h00000100, 2'h0);
            wr(`GLCR_CHANGE_IRQ_DISABLE, 32'h00000100, 2'h0);
            chk("irq", 32'h0, {31'h0, irq});
            ext[p*32+8] <= pins[8];
            repeat (8) @(posedge clk);
            chk("irq", 32'h0, {31'h0, irq});
            rd(`GLCR_CHANGE_IRQ_MASK, 32'h0, 2'h0);
            // Frozen sampling holds the old level of line 9
            @(posedge clk);
            ce <= 0;
            ext[p*32+9] <= ~pins[9];
            repeat (6) @(posedge clk);
            ce <= 1;
            rd(`GLCR_LINE_LEVEL_STATUS, (pins & ~32'hcf) | 32'h40, 2'h0);
            repeat (4) @(posedge clk);
            rd(`GLCR_LINE_LEVEL_STATUS, ((pins & ~32'hcf) | 32'h40) ^ 32'h200, 2'h0);
            rd(9'h00c, 32'h0, 2'h2);
            wr(9'h00c, 32'hffffffff, 2'h2);
        end
        print_verdict;
    end
endmodule // glcr_port_tb
